// File: rtl/mpe_com_decode.sv
/*
 * Serial port address decode and interrupt line steering.
 * Assumes io address and strobe are synchronous to the clock.
 */
`timescale 1ns/1ps
`include "mpe_params.svh"

module mpe_com_decode (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Configuration
    input wire logic alt_sel_i,
    // Io cycle and uart interrupt
    input wire logic [15:0] io_addr_i,
    input wire logic io_strobe_i,
    input wire logic uart_irq_i,
    // Results
    output logic com_sel_o,
    output logic irq3_o,
    output logic irq4_o
);

    logic [15:0] base;

    // Eight-byte window, base picked by configuration
    assign base = alt_sel_i ? `MPE_COM_BASE_ALT : `MPE_COM_BASE_PRI;
    assign com_sel_o = io_strobe_i &
        (io_addr_i[15:3] == base[15:3]);
    assign irq3_o = uart_irq_i & ~alt_sel_i;
    assign irq4_o = uart_irq_i & alt_sel_i;

    a_com_window: assert property (@(posedge clock_i)
        disable iff (rst_i) com_sel_o |-> (alt_sel_i ?
        (io_addr_i >= 16'h02e8 && io_addr_i <= 16'h02ef) :
        (io_addr_i >= 16'h03f8 && io_addr_i <= 16'h03ff)))
        else $error("bad window");

endmodule

// File: rtl/mpe_core.sv
/*
 * Modem power and event controller: Wishbone slave, event bits, power
 * sequencing with plane enables and isolation, serial port decode.
 * Assumes a classic Wishbone master on clock_i and synchronous inputs.
 */
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "mpe_params.svh"

module mpe_core #(
    parameter int N_EVT = 3
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Platform events and ring
    input wire logic [N_EVT-1:0] event_i,
    input wire logic phone_wake_line_i,
    output logic os_event_interrupt_o,
    // Power planes and isolation
    output logic main_power_plane_o,
    output logic aux_plane_enable_o,
    output logic main_iso_o,
    output logic aux_iso_o,
    // Modem controller and phone side
    output logic modem_low_power_req_o,
    output logic modem_off_req_o,
    output logic speaker_en_o,
    output logic phone_if_power_o,
    // Serial port decode
    input wire logic [15:0] io_addr_i,
    input wire logic io_strobe_i,
    input wire logic uart_irq_i,
    output logic com_sel_o,
    output logic com_irq3_o,
    output logic com_irq4_o
);

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam int EW = N_EVT + 1;
    localparam int SETTLE_CYC = (`MPE_SETTLE_NS + `MPE_CLK_PERIOD_NS - 1)
        / `MPE_CLK_PERIOD_NS;
    localparam int CW = $clog2(SETTLE_CYC + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYC - 1);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire hit_sts = wb_adr_i == `MPE_OFS_EVT_STATUS;
    wire hit_en = wb_adr_i == `MPE_OFS_EVT_ENABLE;
    wire hit_ctrl = wb_adr_i == `MPE_OFS_PWR_CTRL;
    wire hit_stat = wb_adr_i == `MPE_OFS_PWR_STATUS;
    wire hit_cfg = wb_adr_i == `MPE_OFS_COM_CFG;

    // Answer one cycle after the request, drop it in the next
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= bus_req;
            rdata_r <= bus_req ? rdata_nxt : rdata_r;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // ------------------------------------------------------------
    // Event status and enable
    // ------------------------------------------------------------
    logic [EW-1:0] en_r;
    logic [EW-1:0] sts;
    logic [EW-1:0] pend;
    wire [EW-1:0] evt_in = {phone_wake_line_i, event_i};
    wire [EW-1:0] sts_clr = (bus_wr & hit_sts) ? wb_dat_i[EW-1:0]
        : {EW{1'b0}};

    // Enable register, software owned
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            en_r <= {EW{1'b0}};
        end else if (bus_wr & hit_en) begin
            en_r <= wb_dat_i[EW-1:0];
        end
    end

    // One sticky bit per event pin
    for (genvar g = 0; g < EW; g++) begin : g_evt
        mpe_evt_bit u_bit (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .set_i(evt_in[g]),
            .clr_i(sts_clr[g]),
            .en_i(en_r[g]),
            .sts_o(sts[g]),
            .pend_o(pend[g])
        );
    end

    // Ring wake needs no plane: event logic sits on core power
    assign os_event_interrupt_o = |pend;

    // ------------------------------------------------------------
    // Power control register
    // ------------------------------------------------------------
    logic [1:0] req_state_r;
    logic main_keep_r;
    logic aux_keep_r;
    logic alt_sel_r;

    // Requested state and plane keep bits; keep bits let software
    // hold a plane for other devices sharing it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            req_state_r <= mpe_pkg::DST_D0;
            main_keep_r <= 1'b1;
            aux_keep_r <= 1'b1;
        end else if (bus_wr & hit_ctrl) begin
            req_state_r <= wb_dat_i[`MPE_CTRL_DSTATE_LSB +: 2];
            main_keep_r <= wb_dat_i[`MPE_CTRL_MAIN_KEEP];
            aux_keep_r <= wb_dat_i[`MPE_CTRL_AUX_KEEP];
        end
    end

    // Serial port resource choice
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            alt_sel_r <= 1'b0;
        end else if (bus_wr & hit_cfg) begin
            alt_sel_r <= wb_dat_i[`MPE_CFG_ALT];
        end
    end

    // ------------------------------------------------------------
    // Power sequencer
    // ------------------------------------------------------------
    mpe_pkg::mpe_seq_type seq_r;
    mpe_pkg::mpe_seq_type seq_nxt;
    logic [1:0] cur_state_r;
    logic [1:0] tgt_state_r;
    logic tgt_main_r;
    logic tgt_aux_r;
    logic main_en_r;
    logic aux_en_r;
    logic main_iso_r;
    logic aux_iso_r;
    logic [CW-1:0] cnt_r;

    // Plane needs per state, plus software keep bits
    wire req_d0 = req_state_r == mpe_pkg::DST_D0;
    wire req_d1 = req_state_r == mpe_pkg::DST_D1;
    wire want_main = main_keep_r | req_d0 | req_d1;
    wire want_aux = aux_keep_r | req_d0;
    wire change = (req_state_r != cur_state_r) |
        (want_main != main_en_r) | (want_aux != aux_en_r);
    wire settle_done = cnt_r == '0;
    // Step order: isolate falling planes, switch, settle, commit
    always_comb begin
        case (seq_r)
            mpe_pkg::SEQ_STABLE:
                seq_nxt = change ? mpe_pkg::SEQ_ISOLATE : mpe_pkg::SEQ_STABLE;
            mpe_pkg::SEQ_ISOLATE:
                seq_nxt = mpe_pkg::SEQ_SWITCH;
            mpe_pkg::SEQ_SWITCH:
                seq_nxt = mpe_pkg::SEQ_SETTLE;
            mpe_pkg::SEQ_SETTLE:
                seq_nxt = settle_done ? mpe_pkg::SEQ_STABLE
                    : mpe_pkg::SEQ_SETTLE;
            default:
                seq_nxt = mpe_pkg::SEQ_STABLE;
        endcase
    end
    // Sequencer state
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            seq_r <= mpe_pkg::SEQ_STABLE;
        end else begin
            seq_r <= seq_nxt;
        end
    end
    // Target latched on start so mid-sequence writes wait their turn
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tgt_state_r <= mpe_pkg::DST_D0;
            tgt_main_r <= 1'b1;
            tgt_aux_r <= 1'b1;
        end else if (seq_r == mpe_pkg::SEQ_STABLE) begin
            tgt_state_r <= req_state_r;
            tgt_main_r <= want_main;
            tgt_aux_r <= want_aux;
        end
    end
    // Isolation rises before a plane drops, falls after it settles
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            main_iso_r <= 1'b0;
            aux_iso_r <= 1'b0;
        end else if (seq_r == mpe_pkg::SEQ_ISOLATE) begin
            main_iso_r <= main_iso_r | ~tgt_main_r;
            aux_iso_r <= aux_iso_r | ~tgt_aux_r;
        end else if (seq_r == mpe_pkg::SEQ_SETTLE && settle_done) begin
            main_iso_r <= ~tgt_main_r;
            aux_iso_r <= ~tgt_aux_r;
        end
    end
    // Plane enables, on at reset so the modem starts in D0
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            main_en_r <= 1'b1;
            aux_en_r <= 1'b1;
        end else if (seq_r == mpe_pkg::SEQ_SWITCH) begin
            main_en_r <= tgt_main_r;
            aux_en_r <= tgt_aux_r;
        end
    end
    // Settle counter; planes need time before the modem sees its state
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (seq_r == mpe_pkg::SEQ_SWITCH) begin
            cnt_r <= SETTLE_LAST;
        end else if (!settle_done) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
    // Commit the modem state only after planes are settled, so aux
    // is already gone, unless its keep bit holds it, when the low power request rises
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cur_state_r <= mpe_pkg::DST_D0;
        end else if (seq_r == mpe_pkg::SEQ_SETTLE && settle_done) begin
            cur_state_r <= tgt_state_r;
        end
    end

    // ------------------------------------------------------------
    // Modem side outputs
    // ------------------------------------------------------------
    wire cur_d0 = cur_state_r == mpe_pkg::DST_D0;
    wire cur_d1 = cur_state_r == mpe_pkg::DST_D1;
    assign modem_low_power_req_o = cur_d1;
    assign modem_off_req_o = ~cur_d0 & ~cur_d1;
    assign speaker_en_o = cur_d0;
    assign phone_if_power_o = cur_d0;
    assign main_power_plane_o = main_en_r;
    assign aux_plane_enable_o = aux_en_r;
    assign main_iso_o = main_iso_r;
    assign aux_iso_o = aux_iso_r;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [31:0] stat_word = {23'h0, modem_off_req_o, modem_low_power_req_o,
        aux_iso_r, main_iso_r, aux_en_r, main_en_r,
        seq_r != mpe_pkg::SEQ_STABLE, cur_state_r};
    wire [31:0] ctrl_word = {28'h0, aux_keep_r, main_keep_r, req_state_r};
    assign rdata_nxt = hit_sts ? {{(32-EW){1'b0}}, sts}
        : hit_en ? {{(32-EW){1'b0}}, en_r}
        : hit_ctrl ? ctrl_word
        : hit_stat ? stat_word
        : hit_cfg ? {31'h0, alt_sel_r}
        : 32'h0;

    // ------------------------------------------------------------
    // Serial port decode
    // ------------------------------------------------------------
    mpe_com_decode u_com (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .alt_sel_i(alt_sel_r),
        .io_addr_i(io_addr_i),
        .io_strobe_i(io_strobe_i),
        .uart_irq_i(uart_irq_i),
        .com_sel_o(com_sel_o),
        .irq3_o(com_irq3_o),
        .irq4_o(com_irq4_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_aux_drop;
        $fell(aux_en_r);
    endsequence
    sequence s_enter_d1;
        $rose(modem_low_power_req_o);
    endsequence
    // Settle length counted apart from the sequencer's own counter
    logic [CW-1:0] settle_len_r;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            settle_len_r <= '0;
        end else begin
            settle_len_r <= (seq_r == mpe_pkg::SEQ_SETTLE) ?
                settle_len_r + 1'b1 : '0;
        end
    end
    a_irq_follows: assert property (@(posedge clock_i)
        disable iff (rst_i) os_event_interrupt_o == |(sts & en_r))
        else $error("interrupt mismatch");
    a_event_sets: assert property (@(posedge clock_i)
        disable iff (rst_i) evt_in[0] |=> sts[0])
        else $error("event not caught");
    a_ring_wakes: assert property (@(posedge clock_i)
        disable iff (rst_i) phone_wake_line_i && en_r[EW-1] |=>
        os_event_interrupt_o) else $error("ring did not wake");
    a_d0_planes: assert property (@(posedge clock_i)
        disable iff (rst_i) cur_d0 && seq_r == mpe_pkg::SEQ_STABLE |->
        main_en_r && aux_en_r) else $error("D0 unpowered");
    a_aux_before_d1: assert property (@(posedge clock_i)
        disable iff (rst_i) s_enter_d1 |-> !aux_en_r || aux_keep_r)
        else $error("aux on at D1");
    a_iso_on_drop: assert property (@(posedge clock_i)
        disable iff (rst_i) s_aux_drop |-> aux_iso_r)
        else $error("aux not isolated");
    a_settle_time: assert property (@(posedge clock_i)
        disable iff (rst_i) seq_r == mpe_pkg::SEQ_SETTLE && settle_done
        |-> settle_len_r == SETTLE_LAST ##1 seq_r == mpe_pkg::SEQ_STABLE)
        else $error("settle length wrong");
    a_off_in_d3: assert property (@(posedge clock_i)
        disable iff (rst_i) cur_state_r == mpe_pkg::DST_D3 |->
        modem_off_req_o && !modem_low_power_req_o && !speaker_en_o)
        else $error("D3 lines wrong");
    a_state_read: assert property (@(posedge clock_i)
        disable iff (rst_i) bus_req && hit_stat |=> wb_ack_o &&
        wb_dat_o[1:0] == $past(cur_state_r)) else $error("state readback");

endmodule

// File: rtl/mpe_evt_bit.sv
/*
 * One sticky event status bit with its enable gate.
 * Assumes set and clear are single-cycle synchronous strobes.
 */
`timescale 1ns/1ps

module mpe_evt_bit (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Event and software controls
    input wire logic set_i,
    input wire logic clr_i,
    input wire logic en_i,
    // Results
    output logic sts_o,
    output logic pend_o
);

    logic sts_r;
    logic sts_nxt;

    // Set beats clear so an event in the clearing cycle survives
    assign sts_nxt = set_i | (sts_r & ~clr_i);
    assign sts_o = sts_r;
    assign pend_o = sts_r & en_i;

    // Status flop, cleared at reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sts_r <= 1'b0;
        end else begin
            sts_r <= sts_nxt;
        end
    end

    a_set_wins: assert property (@(posedge clock_i)
        disable iff (rst_i) set_i |=> sts_r) else $error("event lost");

    a_clear_takes: assert property (@(posedge clock_i)
        disable iff (rst_i) clr_i && !set_i |=> !sts_r)
        else $error("clear ignored");

endmodule

// File: rtl/mpe_params.svh
/*
 * Constants of the modem power and event controller: register offsets,
 * field positions, reset values and timing figures.
 * Assumes it is included by bare name wherever these numbers are used.
 */
`ifndef MPE_PARAMS_SVH
`define MPE_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define MPE_OFS_EVT_STATUS 8'h00
`define MPE_OFS_EVT_ENABLE 8'h04
`define MPE_OFS_PWR_CTRL 8'h08
`define MPE_OFS_PWR_STATUS 8'h0c
`define MPE_OFS_COM_CFG 8'h10

// ------------------------------------------------------------
// Power control fields
// ------------------------------------------------------------
`define MPE_CTRL_DSTATE_LSB 0
`define MPE_CTRL_MAIN_KEEP 2
`define MPE_CTRL_AUX_KEEP 3
`define MPE_CTRL_RESET 32'h0000_000c

// ------------------------------------------------------------
// Power status fields
// ------------------------------------------------------------
`define MPE_STAT_DSTATE_LSB 0
`define MPE_STAT_BUSY 2
`define MPE_STAT_MAIN_EN 3
`define MPE_STAT_AUX_EN 4
`define MPE_STAT_MAIN_ISO 5
`define MPE_STAT_AUX_ISO 6
`define MPE_STAT_LOW_REQ 7
`define MPE_STAT_OFF_REQ 8

// ------------------------------------------------------------
// Serial port configuration
// ------------------------------------------------------------
`define MPE_CFG_ALT 0
`define MPE_COM_BASE_PRI 16'h03f8
`define MPE_COM_BASE_ALT 16'h02e8

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define MPE_CLK_PERIOD_NS 100
`define MPE_SETTLE_NS 10000

`endif

// File: rtl/mpe_pkg.sv
/*
 * Types of the modem power and event controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mpe_pkg;

    // Device power states as held in software-visible fields
    typedef enum logic [1:0] {
        DST_D0 = 2'h0,
        DST_D1 = 2'h1,
        DST_D2 = 2'h2,
        DST_D3 = 2'h3
    } mpe_dstate_type;

    // Power sequencer states, one-hot
    typedef enum logic [3:0] {
        SEQ_STABLE = 4'h1,
        SEQ_ISOLATE = 4'h2,
        SEQ_SWITCH = 4'h4,
        SEQ_SETTLE = 4'h8
    } mpe_seq_type;

endpackage

// File: verification/mpe_modem_model.sv
/*
 * Far-side model: the phone interface ring detector of the modem.
 * Assumes the bench commands each ring; it needs no plane power.
 */
`timescale 1ns/1ps

module mpe_modem_model (
    // Clock and ring command
    input wire logic clock_i,
    input wire logic ring_cmd_i,
    // Ring line to the controller
    output logic phone_wake_line_o
);
    // ---------------------------------------------------------
    // Ring detect
    // ---------------------------------------------------------
    // Line powered, so no plane gates it, even with the modem off
    always_ff @(posedge clock_i) begin
        phone_wake_line_o <= ring_cmd_i;
    end
endmodule

// File: verification/test_modem_power_event_control.sv
/*
 * Self-checking bench of the modem power and event controller.
 * Assumes the controller answers Wishbone and runs its own sequencer.
 */
`timescale 1ns/1ps

module test_modem_power_event_control;
    // ---------------------------------------------------------
    // Signals
    // ---------------------------------------------------------
    logic clock_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [2:0] event_i;
    logic phone_wake_line_i, irq, ring_cmd, main_o, aux_o, main_iso;
    logic aux_iso, low_o, off_o, spk_o, phone_o, sel_o, irq3_o, irq4_o;
    logic [15:0] io_addr_i;
    logic io_strobe_i, uart_irq_i;
    int n_mismatch, tests_run, cycles;
    // Modem side pins gathered for one compare
    wire [7:0] pins = {main_o, aux_o, main_iso, aux_iso, low_o, off_o,
        spk_o, phone_o};

    mpe_core #(.N_EVT(3)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_i(event_i),
        .phone_wake_line_i(phone_wake_line_i),
        .os_event_interrupt_o(irq), .main_power_plane_o(main_o),
        .aux_plane_enable_o(aux_o), .main_iso_o(main_iso),
        .aux_iso_o(aux_iso), .modem_low_power_req_o(low_o),
        .modem_off_req_o(off_o), .speaker_en_o(spk_o),
        .phone_if_power_o(phone_o), .io_addr_i(io_addr_i),
        .io_strobe_i(io_strobe_i), .uart_irq_i(uart_irq_i),
        .com_sel_o(sel_o), .com_irq3_o(irq3_o), .com_irq4_o(irq4_o));

    mpe_modem_model model_u (.clock_i(clock_i), .ring_cmd_i(ring_cmd),
        .phone_wake_line_o(phone_wake_line_i));

    // Clock of 100 ns
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // Hang guard, well above the thousand or so cycles the tests need
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ---------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t got %h expected %h", $time, got,
                exp);
        end
    endtask

    // One classic cycle; request held until ack is seen
    task automatic wb_xfer(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        // Ack ends this wait; only the bench's hang guard ends it if ack never comes
        do begin
            @(posedge clock_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Irq is a level, looked at mid-cycle once the edge has landed
    task automatic irq_is(input logic e);
        @(negedge clock_i);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // Request a state, wait out busy, then check status and pins
    task automatic pwr_to(input logic [3:0] c);
        logic [1:0] d;
        logic m, a, lo, off, on;
        logic [7:0] ep;
        int n;
        d = c[1:0];
        m = c[2] | (d <= 2'h1);
        a = c[3] | (d == 2'h0);
        lo = (d == 2'h1);
        off = d[1];
        on = (d == 2'h0);
        wr(8'h08, {28'h0, c});
        repeat (4) @(posedge clock_i);
        n = 0;
        do begin
            wb_xfer(1'b0, 8'h0c, 32'h0);
            n++;
        end while (rd[2] !== 1'b0 && n < 100);
        chk(rd, {23'h0, off, lo, ~a, ~m, a, m, 1'b0, d});
        ep = {m, a, ~m, ~a, lo, off, on, on};
        chk({24'h0, pins}, {24'h0, ep});
    endtask

    task automatic io_t(input logic [15:0] a, input logic [2:0] e);
        @(posedge clock_i);
        io_addr_i <= a;
        io_strobe_i <= 1'b1;
        uart_irq_i <= 1'b1;
        @(negedge clock_i);
        chk({29'h0, sel_o, irq3_o, irq4_o}, {29'h0, e});
    endtask

    // ---------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------
    task automatic t_reset;
        rdc(8'h0c, 32'h18);
        chk({24'h0, pins}, 32'hc3);
        rdc(8'h08, 32'hc);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        wr(8'h0c, 32'hffffffff);
        rdc(8'h0c, 32'h18);
        rdc(8'h20, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_evt;
        @(posedge clock_i);
        event_i <= 3'h3;
        @(posedge clock_i);
        event_i <= 3'h0;
        rdc(8'h00, 32'h3);
        irq_is(1'b0);
        wr(8'h04, 32'hff);
        rdc(8'h04, 32'hf);
        irq_is(1'b1);
        wr(8'h04, 32'h0);
        irq_is(1'b0);
        // Clear and a fresh event meet at the same edge
        fork
            wr(8'h00, 32'h1);
            begin
                @(posedge clock_i);
                event_i <= 3'h1;
                @(posedge clock_i);
                event_i <= 3'h0;
            end
        join
        rdc(8'h00, 32'h3);
        wr(8'h00, 32'h2);
        rdc(8'h00, 32'h1);
        wr(8'h00, 32'h1);
        rdc(8'h00, 32'h0);
        $display("test events done");
    endtask

    task automatic t_pwr;
        pwr_to(4'h1);
        pwr_to(4'h0);
        pwr_to(4'h1);
        pwr_to(4'h3);
        pwr_to(4'h7);
        pwr_to(4'h2);
        pwr_to(4'h0);
        $display("test power done");
    endtask

    task automatic t_ring;
        pwr_to(4'h3);
        wr(8'h04, 32'h8);
        @(posedge clock_i);
        ring_cmd <= 1'b1;
        @(posedge clock_i);
        ring_cmd <= 1'b0;
        rdc(8'h00, 32'h8);
        irq_is(1'b1);
        wr(8'h00, 32'h8);
        irq_is(1'b0);
        wr(8'h04, 32'h0);
        pwr_to(4'h0);
        $display("test ring done");
    endtask

    task automatic t_com;
        io_t(16'h03f8, 3'h6);
        io_t(16'h03ff, 3'h6);
        io_t(16'h02e8, 3'h2);
        wr(8'h10, 32'h1);
        io_t(16'h02ef, 3'h5);
        io_t(16'h03f8, 3'h1);
        $display("test serial port done");
    endtask

    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, ring_cmd, io_strobe_i} = 5'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, event_i} = 47'h0;
        {io_addr_i, uart_irq_i} = 17'h0;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_evt();
        t_pwr();
        t_ring();
        t_com();
        wrap_up();
    end
endmodule
